// ---- core/bcm_ctrl.sv ----
// Switch sequencing, protection and register access of the buck controller.
//
// Operation
// RULE1: Cycle starts switch on; peak turns off.
// RULE2: Valid valley in secondary starts next cycle.
// RULE3: Valley needs ringing and swing in range.
// RULE4: Without valley, maximum off-time starts cycle.
// RULE5: Coil and output shorts latch halt.
// RULE6: Supply below reset level clears latch.
// RULE7: Overheat faults halt, then restart via lockout.
// RULE8: Switching starts only with no fault.
// RULE9: Below stop: stop, enable startup source; a latched halt stays in ST_LATCH with the source off.
// RULE10: Sense ignored during blanking after turn-on.
// RULE11: After blanking, sense limit turns switch off.
// RULE12: Die overheat stops until release temperature.
// RULE13: Maximum on-time forces switch off.
// RULE14: Sense above short level latches coil fault.
// RULE15: Off-time expiry starts short detect timer.
// RULE16: Valid valley or stop clears timer.
// RULE17: Maximum on-time clears short detect timer.
// RULE18: Timer expiry latches output short fault.
// RULE19: Start above start level, stop below stop.
// RULE20: Startup source on until supply takes over.
// RULE21: Flags synchronised; intervals are cycle counters.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module bcm_ctrl #(
	parameter int LEB_P  = bcm_pkg::LEB_CYC,
	parameter int TON_P  = bcm_pkg::TON_CYC,
	parameter int TOFF_P = bcm_pkg::TOFF_CYC,
	parameter int SC_P   = bcm_pkg::SC_CYC
) (
	// Clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [bcm_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output var  logic [31:0]               prdata,
	output var  logic                      pready,
	output var  logic                      pslverr,
	// Comparator flags from the analog side
	input  wire bcm_pkg::bcm_cmp_t         cmp_in,
	// Power stage
	output var  logic                      gate_on,
	output var  logic                      high_voltage_startup_pin,
	// Fault status
	output var  logic                      shorted_coil_fault,
	output var  logic                      output_short_fault
);
	import bcm_pkg::*;

	localparam logic [CNT_W-1:0] LEB_L  = CNT_W'(LEB_P);
	localparam logic [CNT_W-1:0] TON_L  = CNT_W'(TON_P - 1);
	localparam logic [CNT_W-1:0] TOFF_L = CNT_W'(TOFF_P - 1);
	localparam logic [CNT_W-1:0] SC_L   = CNT_W'(SC_P - 1);

	bcm_reg_t r_ff;
	bcm_reg_t nxt_r;
	bcm_cmp_t c;

	logic valid_valley;
	logic past_blank;
	logic fault_present;
	logic sc_expire;
	logic running;
	logic wr_ctrl;
	logic rd_setup;

	// ********************************************************************
	// Comparator synchronisation
	// ********************************************************************
	// Every analog flag crosses in through two flops before any use.
	bcm_sync #(
		.W(CMP_W)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (cmp_in),
		.q       (c)
	); // RULE21

	// ********************************************************************
	// Combinational terms
	// ********************************************************************
	assign valid_valley  = c.valley & c.ring_ok & c.swing_ok; // RULE3
	assign past_blank    = r_ff.on_cnt >= LEB_L; // RULE10
	assign fault_present = r_ff.shorted_coil_fault | r_ff.output_short_fault
		| r_ff.otp | c.die_trip | c.led_hot; // RULE8
	assign sc_expire     = r_ff.sc_run && (r_ff.sc_cnt == SC_L);
	assign running       = (r_ff.state == ST_PRI) || (r_ff.state == ST_SEC);
	assign wr_ctrl  = psel && penable && pwrite && (paddr == ADDR_CTRL);
	assign rd_setup = psel && !penable && !pwrite;

	// ********************************************************************
	// Next state
	// ********************************************************************
	always_comb begin
		nxt_r = r_ff;

		// The short detect timer runs on its own beside the cycle.
		if (r_ff.sc_run) begin
			nxt_r.sc_cnt = r_ff.sc_cnt + 1'b1; // RULE21
		end

		case (r_ff.state)
			ST_LOCK: begin
				nxt_r.on_cnt = '0;
				if (c.above_start && !c.below_stop && !fault_present
					&& r_ff.enable) begin
					nxt_r.state   = ST_PRI; // RULE19 RULE8
					nxt_r.startup = 1'b1; // RULE20
				end
			end
			ST_PRI: begin
				nxt_r.on_cnt = r_ff.on_cnt + 1'b1;
				if (past_blank && c.coil_short) begin
					nxt_r.shorted_coil_fault = 1'b1; // RULE14
					nxt_r.state              = ST_LATCH; // RULE5
				end else if (r_ff.on_cnt == TON_L) begin
					nxt_r.state   = ST_SEC; // RULE13
					nxt_r.off_cnt = '0;
					nxt_r.sc_run  = 1'b0; // RULE17
					nxt_r.sc_cnt  = '0;
				end else if (past_blank && c.peak) begin
					nxt_r.state   = ST_SEC; // RULE1 RULE11
					nxt_r.off_cnt = '0;
				end
			end
			ST_SEC: begin
				nxt_r.off_cnt = r_ff.off_cnt + 1'b1;
				if (valid_valley) begin
					nxt_r.state  = ST_PRI; // RULE2
					nxt_r.on_cnt = '0;
					nxt_r.sc_run = 1'b0; // RULE16
					nxt_r.sc_cnt = '0;
				end else if (r_ff.off_cnt == TOFF_L) begin
					nxt_r.state  = ST_PRI; // RULE4
					nxt_r.on_cnt = '0;
					if (!r_ff.sc_run) begin
						nxt_r.sc_run = 1'b1; // RULE15
						nxt_r.sc_cnt = '0;
					end
				end
			end
			ST_RESTART: begin
				// Startup source stays off so the supply decays to stop.
				nxt_r.on_cnt = '0;
			end
			ST_LATCH: begin
				nxt_r.on_cnt = '0;
			end
			default: begin
				nxt_r.state = ST_LOCK;
			end
		endcase

		// Timer ran out with neither valley nor on-time limit.
		if (sc_expire && nxt_r.sc_run) begin
			nxt_r.output_short_fault = 1'b1; // RULE18
			nxt_r.state              = ST_LATCH; // RULE5
		end
		// A latched halt stops and clears the timer so the fault pair stays as set.
		if (nxt_r.state == ST_LATCH) begin
			nxt_r.sc_run = 1'b0; // RULE5
			nxt_r.sc_cnt = '0;
		end

		// Software may halt conversion; it then waits in lockout.
		if (running && !r_ff.enable) begin
			nxt_r.state  = ST_LOCK;
			nxt_r.sc_run = 1'b0;
			nxt_r.sc_cnt = '0;
		end

		// Overheat flags: die trip is sticky until the release level.
		if (c.die_trip) begin
			nxt_r.otp = 1'b1; // RULE12
		end else if (c.die_release) begin
			nxt_r.otp = 1'b0; // RULE12
		end
		if (running && (c.die_trip || c.led_hot)) begin
			nxt_r.state = ST_RESTART; // RULE7
		end

		if (c.supply_ok) begin
			nxt_r.startup = 1'b0; // RULE20
		end

		// Below stop the core locks out; a latched halt stays halted.
		if (c.below_stop) begin
			nxt_r.sc_run = 1'b0; // RULE16
			nxt_r.sc_cnt = '0;
			if (r_ff.state != ST_LATCH) begin
				nxt_r.state = ST_LOCK; // RULE9 RULE19
			end
		end

		// Only a supply collapse to the reset level frees the latch.
		if (c.below_reset) begin
			nxt_r.shorted_coil_fault = 1'b0; // RULE6
			nxt_r.output_short_fault = 1'b0; // RULE6
			nxt_r.sc_run             = 1'b0;
			nxt_r.sc_cnt             = '0;
			if (nxt_r.state != ST_PRI && nxt_r.state != ST_SEC) begin
				nxt_r.state = ST_LOCK;
			end
		end

		// ****************************************************************
		// Register access
		// ****************************************************************
		if (wr_ctrl) begin
			nxt_r.enable = pwdata[CTRL_EN_BIT];
		end
		if (rd_setup) begin
			nxt_r.rdata = '0;
			if (paddr == ADDR_CTRL) begin
				nxt_r.rdata[CTRL_EN_BIT] = r_ff.enable;
			end else if (paddr == ADDR_STATUS) begin
				nxt_r.rdata[STAT_ST_LSB +: 5]  = r_ff.state;
				nxt_r.rdata[STAT_COIL_BIT] = r_ff.shorted_coil_fault;
				nxt_r.rdata[STAT_OUTS_BIT] = r_ff.output_short_fault;
				nxt_r.rdata[STAT_OTP_BIT]  = r_ff.otp;
				nxt_r.rdata[STAT_SC_BIT]   = r_ff.sc_run;
				nxt_r.rdata[STAT_SRC_BIT]  = high_voltage_startup_pin;
				nxt_r.rdata[STAT_GT_BIT]  = gate_on;
				nxt_r.rdata[STAT_SU_BIT]  = r_ff.startup;
			end
		end
	end

	// ********************************************************************
	// State register
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff.state              <= ST_LOCK;
			r_ff.on_cnt             <= '0;
			r_ff.off_cnt            <= '0;
			r_ff.sc_cnt             <= '0;
			r_ff.sc_run             <= 1'b0;
			r_ff.shorted_coil_fault <= 1'b0;
			r_ff.output_short_fault <= 1'b0;
			r_ff.otp                <= 1'b0;
			r_ff.startup            <= 1'b0;
			r_ff.enable             <= CTRL_EN_RST;
			r_ff.rdata              <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign gate_on = (r_ff.state == ST_PRI); // RULE1
	// Recharge in lockout; keep the source on until the supply holds.
	assign high_voltage_startup_pin = (r_ff.state == ST_LOCK)
		|| (running && r_ff.startup); // RULE9 RULE20
	assign shorted_coil_fault = r_ff.shorted_coil_fault;
	assign output_short_fault = r_ff.output_short_fault;
	assign prdata  = r_ff.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable
		&& (paddr != ADDR_CTRL) && (paddr != ADDR_STATUS);

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_blank_over;
		gate_on && past_blank;
	endsequence

	sequence s_peak_seen;
		s_blank_over ##0 c.peak && !c.coil_short;
	endsequence

	sequence s_quiet;
		!c.below_stop && !c.below_reset && !c.die_trip && !c.led_hot
			&& r_ff.enable && !sc_expire;
	endsequence

	AST_PEAK_OFF: assert property ( // RULE11
		s_peak_seen ##0 s_quiet |=> !gate_on ##0 r_ff.state == ST_SEC)
		else $error("peak after blanking did not end the on phase");

	AST_BLANK: assert property ( // RULE10
		gate_on && !past_blank && !r_ff.shorted_coil_fault
			&& !c.below_reset |=> !r_ff.shorted_coil_fault)
		else $error("coil fault raised inside blanking");

	AST_COIL_LATCH: assert property ( // RULE14
		s_blank_over ##0 c.coil_short && !c.below_reset
			|=> shorted_coil_fault && !gate_on)
		else $error("coil short after blanking not latched");

	AST_LATCH_HOLD: assert property ( // RULE5
		(shorted_coil_fault || output_short_fault) && !c.below_reset
			|=> !gate_on && $stable({shorted_coil_fault,
				output_short_fault}))
		else $error("latched fault lost or switching resumed");

	AST_RESET_CLEAR: assert property ( // RULE6
		c.below_reset |=> !shorted_coil_fault && !output_short_fault)
		else $error("reset level did not clear latched faults");

	AST_TON_MAX: assert property ( // RULE13
		gate_on && r_ff.on_cnt == TON_L |=> !gate_on && !r_ff.sc_run)
		else $error("on phase outlived the maximum on-time");

	AST_VALLEY: assert property ( // RULE2
		r_ff.state == ST_SEC && valid_valley ##0 s_quiet
			|=> gate_on && r_ff.on_cnt == '0 && !r_ff.sc_run)
		else $error("valid valley did not start the next cycle");

	AST_BAD_VALLEY: assert property ( // RULE3
		r_ff.state == ST_SEC && c.valley && !valid_valley
			&& r_ff.off_cnt < TOFF_L ##0 s_quiet
			|=> r_ff.state == ST_SEC)
		else $error("out of range valley was accepted");

	AST_TOFF_MAX: assert property ( // RULE4
		r_ff.state == ST_SEC && !valid_valley && r_ff.off_cnt == TOFF_L
			##0 s_quiet |=> gate_on && r_ff.sc_run)
		else $error("off-time expiry did not restart and arm timer");

	AST_SC_EXPIRE: assert property ( // RULE18
		sc_expire && !c.below_stop && !c.below_reset
			&& !(gate_on && r_ff.on_cnt == TON_L)
			&& !(r_ff.state == ST_SEC && valid_valley)
			|=> output_short_fault ##1 !gate_on)
		else $error("short timer expiry did not latch the fault");

	AST_STOP: assert property ( // RULE9
		c.below_stop && !shorted_coil_fault && !output_short_fault
			&& !c.below_reset |=> !gate_on && high_voltage_startup_pin
			&& !r_ff.sc_run)
		else $error("stop level did not lock out and recharge");

	AST_START: assert property ( // RULE19
		r_ff.state == ST_LOCK && c.above_start && !c.below_stop
			&& !fault_present && r_ff.enable && !c.below_reset
			|=> gate_on && high_voltage_startup_pin == !$past(c.supply_ok))
		else $error("start level did not begin switching");

	AST_HOT_HALT: assert property ( // RULE7
		running && (c.die_trip || c.led_hot) && !c.below_stop
			&& !c.below_reset |=> !gate_on && !high_voltage_startup_pin)
		else $error("overheat did not halt with source off");

endmodule
`default_nettype wire

// ---- core/bcm_pkg.sv ----
// Shared constants and types of the buck switch controller core.
package bcm_pkg;

	// ********************************************************************
	// Clock and interval figures
	// ********************************************************************
	localparam int CLK_MHZ      = 125;
	localparam int CNT_W        = 16;
	localparam int T_LEB_NS     = 400;
	localparam int T_ON_MAX_NS  = 20000;
	localparam int T_OFF_MAX_NS = 28000;
	localparam int SHORT_DETECT_INTERVAL_NS  = 32000;
	// A least time rounds up, longest times round down.
	localparam int LEB_CYC  = (T_LEB_NS * CLK_MHZ + 999) / 1000;
	localparam int TON_CYC  = (T_ON_MAX_NS * CLK_MHZ) / 1000;
	localparam int TOFF_CYC = (T_OFF_MAX_NS * CLK_MHZ) / 1000;
	localparam int SC_CYC   = (SHORT_DETECT_INTERVAL_NS * CLK_MHZ) / 1000;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam int         CTRL_EN_BIT  = 0;
	localparam logic       CTRL_EN_RST  = 1'b1;
	localparam int         STAT_ST_LSB  = 0;
	localparam int         STAT_COIL_BIT = 8;
	localparam int         STAT_OUTS_BIT = 9;
	localparam int         STAT_OTP_BIT  = 10;
	localparam int         STAT_SC_BIT   = 11;
	localparam int         STAT_SRC_BIT  = 12;
	localparam int         STAT_GT_BIT   = 13;
	localparam int         STAT_SU_BIT   = 14;

	// ********************************************************************
	// Types
	// ********************************************************************
	typedef enum logic [4:0] {
		ST_LOCK    = 5'b00001,
		ST_PRI     = 5'b00010,
		ST_SEC     = 5'b00100,
		ST_RESTART = 5'b01000,
		ST_LATCH   = 5'b10000
	} bcm_state_t;

	typedef struct packed {
		logic peak;
		logic valley;
		logic ring_ok;
		logic swing_ok;
		logic coil_short;
		logic die_trip;
		logic die_release;
		logic led_hot;
		logic above_start;
		logic below_stop;
		logic below_reset;
		logic supply_ok;
	} bcm_cmp_t;

	localparam int CMP_W = 12;

	typedef struct packed {
		bcm_state_t        state;
		logic [CNT_W-1:0]  on_cnt;
		logic [CNT_W-1:0]  off_cnt;
		logic [CNT_W-1:0]  sc_cnt;
		logic              sc_run;
		logic              shorted_coil_fault;
		logic              output_short_fault;
		logic              otp;
		logic              startup;
		logic              enable;
		logic [31:0]       rdata;
	} bcm_reg_t;

endpackage

// ---- core/bcm_sync.sv ----
// Two-flop synchroniser for the comparator flags.
`timescale 1ns/100ps
`default_nettype none
module bcm_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Flags
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	import bcm_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} bcm_sync_t;

	bcm_sync_t s_ff;
	bcm_sync_t nxt_s;

	// Only the second stage is read, so a metastable first flop never leaks.
	always_comb begin
		nxt_s.meta = d;
		nxt_s.sync = s_ff.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign q = s_ff.sync;
endmodule
`default_nettype wire

// ---- test/bcm_stage_model.sv ----
// Behavioural buck power stage that answers the switch drive with flags.
`timescale 1ns/100ps
`default_nettype none
module bcm_stage_model (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Switch drive and stage setup
	input  wire logic              gate_on,
	input  wire logic [7:0]        pk_dly,
	input  wire logic [7:0]        vl_dly,
	input  wire logic              vl_good,
	input  wire bcm_pkg::bcm_cmp_t base,
	// Comparator flags
	output var  bcm_pkg::bcm_cmp_t cmp_in
);
	import bcm_pkg::*;

	// ********************
	// Coil and drain model
	// ********************
	typedef struct packed {
		logic       g;
		logic [7:0] t;
	} bcm_stage_t;

	bcm_stage_t m_ff;
	bcm_stage_t nxt_m;

	// Cycles since the switch drive last changed; saturates when idle.
	always_comb begin
		nxt_m.g = gate_on;
		nxt_m.t = m_ff.t;
		if (gate_on != m_ff.g)
			nxt_m.t = 8'h00;
		else if (m_ff.t != 8'hff)
			nxt_m.t = m_ff.t + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			m_ff <= '0;
		else
			m_ff <= nxt_m;
	end

	// A zero peak delay stands for a current that never reaches the limit.
	// The valley pulse always comes; only the quality flags make it valid.
	// Flags wait for the count to restart, so a stale count gives no glitch.
	always_comb begin
		cmp_in          = base;
		cmp_in.peak     = gate_on && m_ff.g && pk_dly != 8'h00
			&& m_ff.t >= pk_dly;
		cmp_in.valley   = !gate_on && !m_ff.g && m_ff.t >= vl_dly
			&& m_ff.t < vl_dly + 8'h02;
		cmp_in.ring_ok  = vl_good;
		cmp_in.swing_ok = vl_good;
	end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench of the buck switch controller core.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import bcm_pkg::*;
	localparam int LEB  = 12;
	localparam int TON  = 40;
	localparam int TOFF = 30;
	localparam int SC   = 400;
	localparam int G = 0, H = 1, C = 2, O = 3;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  pk_dly = 8'h14;
	logic [7:0]  vl_dly = 8'h05;
	logic        vl_good = 1'b1;
	bcm_cmp_t    base = 12'h0;
	bcm_cmp_t    cmp_in;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, gate_on, src_on, scf, osf;
	int          num_errors = 0;
	int          checks = 0;
	int          on, off;

	initial begin
		forever #4 pclk = ~pclk;
	end

	bcm_ctrl #(.LEB_P(LEB), .TON_P(TON), .TOFF_P(TOFF), .SC_P(SC)) bcm_ctrl_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_in(cmp_in),
		.gate_on(gate_on), .high_voltage_startup_pin(src_on),
		.shorted_coil_fault(scf), .output_short_fault(osf));

	bcm_stage_model bcm_stage_model_i (
		.pclk(pclk), .presetn(presetn), .gate_on(gate_on), .pk_dly(pk_dly),
		.vl_dly(vl_dly), .vl_good(vl_good), .base(base), .cmp_in(cmp_in));

	// ********************
	// Shared tasks
	// ********************
	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rng(input int v, input int lo, input int hi);
		chk((v >= lo && v <= hi) ? 32'h1 : 32'h0, 32'h1);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			num_errors++;
			finish_test();
		end
	endtask

	task automatic stat(input int b, input logic v);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk({31'h0, rd[b]}, {31'h0, v});
	endtask

	function automatic logic pick(input int s);
		logic [3:0] v;
		v = {osf, scf, src_on, gate_on};
		return v[s];
	endfunction

	// Waits for an output level; a lost design must not hang the run.
	task automatic wt(input int s, input logic v);
		int k;
		k = 0;
		while (pick(s) !== v && k < 2000) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 2000) begin
			num_errors++;
			finish_test();
		end
	endtask

	task automatic span(input logic lvl, output int n);
		wt(G, lvl);
		n = 0;
		while (gate_on === lvl && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 2000) begin
			num_errors++;
			finish_test();
		end
	endtask

	task automatic pulse(output int n_on, output int n_off);
		span(1'b0, n_on);
		span(1'b1, n_on);
		span(1'b0, n_off);
	endtask

	// The first switching cycle may straddle the change, so measure the second.
	task automatic cyc(input logic [7:0] pk, input logic vg);
		pk_dly  <= pk;
		vl_good <= vg;
		pulse(on, off);
		pulse(on, off);
	endtask

	task automatic sup(input logic st, input logic stop, input logic rst);
		@(posedge pclk);
		base.above_start <= st;
		base.below_stop  <= stop;
		base.below_reset <= rst;
	endtask

	// ********************
	// Test sequence
	// ********************
	initial begin
		base.die_release <= 1'b1;
		base.below_stop  <= 1'b1;
		tick(6);
		presetn <= 1'b1;
		tick(1);
		chk({31'h0, src_on}, 32'h1);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h1);
		stat(0, 1'b1);
		apb(1'b1, 8'h08, 32'hffffffff);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		chk({rd[31:1], er}, 32'h1);
		sup(1'b0, 1'b0, 1'b0);
		tick(20);
		chk({31'h0, gate_on}, 32'h0);
		sup(1'b1, 1'b0, 1'b0);
		wt(G, 1'b1);
		chk({31'h0, src_on}, 32'h1);
		base.supply_ok <= 1'b1;
		tick(6);
		chk({31'h0, src_on}, 32'h0);
		$display("test start done");
		cyc(8'h14, 1'b1);
		rng(on, 21, 26);
		rng(off, 6, 11);
		cyc(8'h01, 1'b1);
		rng(on, LEB, LEB + 5);
		cyc(8'h00, 1'b1);
		rng(on, TON - 2, TON + 1);
		cyc(8'h14, 1'b0);
		rng(off, TOFF - 2, TOFF + 1);
		stat(STAT_SC_BIT, 1'b1);
		pk_dly <= 8'h00;
		span(1'b1, on);
		stat(STAT_SC_BIT, 1'b0);
		cyc(8'h14, 1'b1);
		stat(STAT_SC_BIT, 1'b0);
		$display("test cycle done");
		vl_good <= 1'b0;
		wt(O, 1'b1);
		tick(2 * TOFF);
		chk({31'h0, gate_on}, 32'h0);
		sup(1'b0, 1'b1, 1'b0);
		tick(6);
		chk({31'h0, osf}, 32'h1);
		sup(1'b0, 1'b1, 1'b1);
		tick(6);
		chk({31'h0, osf}, 32'h0);
		vl_good <= 1'b1;
		sup(1'b1, 1'b0, 1'b0);
		span(1'b1, on);
		base.coil_short <= 1'b1;
		span(1'b1, on);
		rng(on, LEB, LEB + 5);
		chk({31'h0, scf}, 32'h1);
		tick(10);
		chk({31'h0, gate_on}, 32'h0);
		base.coil_short <= 1'b0;
		sup(1'b0, 1'b1, 1'b1);
		tick(6);
		chk({31'h0, scf}, 32'h0);
		sup(1'b1, 1'b0, 1'b0);
		$display("test fault done");
		for (int i = 0; i < 2; i++) begin
			wt(G, 1'b1);
			base.die_trip    <= (i == 0);
			base.led_hot     <= (i == 1);
			base.die_release <= (i == 1);
			wt(G, 1'b0);
			tick(4);
			chk({31'h0, src_on}, 32'h0);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk({27'h0, rd[4:0]}, {27'h0, ST_RESTART});
			sup(1'b0, 1'b1, 1'b0);
			wt(H, 1'b1);
			sup(1'b1, 1'b0, 1'b0);
			tick(20);
			chk({31'h0, gate_on}, 32'h0);
			base.die_trip    <= 1'b0;
			base.led_hot     <= 1'b0;
			base.die_release <= 1'b1;
			wt(G, 1'b1);
		end
		$display("test overheat done");
		sup(1'b0, 1'b0, 1'b0);
		pulse(on, off);
		rng(on, 21, 26);
		wt(G, 1'b1);
		sup(1'b0, 1'b1, 1'b0);
		tick(5);
		chk({31'h0, gate_on}, 32'h0);
		chk({31'h0, src_on}, 32'h1);
		sup(1'b1, 1'b0, 1'b0);
		wt(G, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h0);
		tick(6);
		chk({31'h0, gate_on}, 32'h0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h1);
		wt(G, 1'b1);
		$display("test control done");
		finish_test();
	end
endmodule
`default_nettype wire
